// File: mla_logic_array.sv
// Purpose: Sixteen-macrocell logic array block with routing, terms and pins
// Assumes: Pins are asynchronous to aclk and are sampled through two flops
// Notes: Programmable clocks become one-cycle enables on aclk
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module mla_logic_array (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [mla_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Write protection, ignored
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [mla_pkg::DATA_W-1:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [mla_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Read protection, ignored
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [mla_pkg::DATA_W-1:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic first_global_clock_pin, // Global clock pin one
  input wire logic second_global_clock_pin, // Global clock pin two
  input wire logic global_clear_pin_n, // Global clear, active low
  input wire logic [mla_pkg::NUM_DED-1:0] ded_in_pin, // Dedicated inputs
  input wire logic [mla_pkg::NUM_MC-1:0] io_pin_in, // I/O pin levels
  output logic [mla_pkg::NUM_MC-1:0] io_pin_out, // I/O pin drive values
  output logic [mla_pkg::NUM_MC-1:0] io_pin_oe // I/O pin drive enables
);
  import mla_pkg::*;

  mla_state_type st_q;
  mla_state_type st_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Product term: at least one literal selected, and all selected true and complement literals hold
  function automatic logic term_hit(input logic [NUM_IN-1:0] v,
                                    input logic [NUM_IN-1:0] tm,
                                    input logic [NUM_IN-1:0] cm);
    logic used;
    used = |(tm | cm);
    term_hit = used && ((v & tm) == tm) && ((~v & cm) == cm);
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] nw,
                                              input logic [3:0] strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = res;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [NUM_IN-1:0] blk_in;
    logic [1:0] gcur;
    logic [1:0] gprev;
    logic [1:0] gtick;
    logic [NUM_TERMS-1:0] hit;
    logic carry;
    logic tot;
    logic sum_i;
    logic kterm;
    logic dsrc;
    logic q;
    logic nq;
    logic tick;
    logic pre;
    logic clr;
    logic [CFG_W-1:0] cfg;
    logic [1:0] ftype;
    logic [DATA_W-1:0] rdat;
    logic rerr;
    logic werr;
    logic [ADDR_W-1:0] off;
    logic [7:0] tix;
    logic [3:0] mix;
    logic [DATA_W-1:0] old;
    logic [DATA_W-1:0] nw;
    st_d = st_q;
    blk_in = '0;
    gcur = '0;
    gprev = '0;
    gtick = '0;
    hit = '0;
    carry = 1'b0;
    tot = 1'b0;
    sum_i = 1'b0;
    kterm = 1'b0;
    dsrc = 1'b0;
    q = 1'b0;
    nq = 1'b0;
    tick = 1'b0;
    pre = 1'b0;
    clr = 1'b0;
    cfg = '0;
    ftype = FF_D;
    rdat = '0;
    rerr = 1'b0;
    werr = 1'b0;
    off = '0;
    tix = '0;
    mix = '0;
    old = '0;
    nw = '0;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    st_d.gpin_s1 = {second_global_clock_pin, first_global_clock_pin};
    st_d.gpin_s2 = st_q.gpin_s1;
    st_d.gpin_s3 = st_q.gpin_s2;
    st_d.gclr_s1 = global_clear_pin_n;
    st_d.gclr_s2 = st_q.gclr_s1;
    st_d.ded_s1 = ded_in_pin;
    st_d.ded_s2 = st_q.ded_s1;
    st_d.io_s1 = io_pin_in;
    st_d.io_s2 = st_q.io_s1;
    st_d.io_dly = st_q.io_s2;

    // ---------------------------------------------------------------
    // Global clocks and routing
    // ---------------------------------------------------------------
    // clock source select
    gcur[0] = st_q.gpin_s2[st_q.gclk_cfg[GCLK_SEL0]] ^ st_q.gclk_cfg[GCLK_INV0];
    gcur[1] = st_q.gpin_s2[st_q.gclk_cfg[GCLK_SEL1]] ^ st_q.gclk_cfg[GCLK_INV1];
    gprev[0] = st_q.gpin_s3[st_q.gclk_cfg[GCLK_SEL0]] ^ st_q.gclk_cfg[GCLK_INV0];
    gprev[1] = st_q.gpin_s3[st_q.gclk_cfg[GCLK_SEL1]] ^ st_q.gclk_cfg[GCLK_INV1];
    gtick = gcur & ~gprev;
    blk_in = {st_q.ded_s2, st_q.io_s2, st_q.mc_out} & st_q.route;
    for (int t = 0; t < NUM_TERMS; t++) begin
      hit[t] = term_hit(blk_in, st_q.t_true[t], st_q.t_comp[t]);
    end

    // ---------------------------------------------------------------
    // Macrocells
    // ---------------------------------------------------------------
    // sixteen macrocells
    for (int i = 0; i < NUM_MC; i++) begin
      cfg = st_q.mc_cfg[i];
      ftype = cfg[CFG_TYPE_LSB +: 2];
      // JK and SR keep the third term for K or R
      if (ftype == FF_JK || ftype == FF_SR) begin
        sum_i = hit[i*TERMS_PER_MC + T_SUM0] | hit[i*TERMS_PER_MC + T_SUM1];
      end else begin
        sum_i = hit[i*TERMS_PER_MC + T_SUM0] | hit[i*TERMS_PER_MC + T_SUM1]
              | hit[i*TERMS_PER_MC + T_SUM2];
      end
      kterm = hit[i*TERMS_PER_MC + T_SUM2];
      tot = sum_i | carry;
      if (cfg[CFG_LEND]) begin
        carry = tot;
        tot = 1'b0;
      end else begin
        carry = 1'b0;
      end
      if (cfg[CFG_FDLY]) begin
        dsrc = st_q.io_dly[i];
      end else begin
        dsrc = st_q.io_s2[i];
      end
      case (cfg[CFG_CLK_LSB +: 2])
        CLK_GLOBAL: tick = gtick[cfg[CFG_GSEL]];
        CLK_GLOBAL_CE: tick = gtick[cfg[CFG_GSEL]] & hit[i*TERMS_PER_MC + T_CLK];
        CLK_ARRAY: tick = hit[i*TERMS_PER_MC + T_CLK] & ~st_q.ac_prev[i];
        default: tick = gtick[cfg[CFG_GSEL]];
      endcase
      st_d.ac_prev[i] = hit[i*TERMS_PER_MC + T_CLK];
      q = st_q.mc_reg[i];
      nq = q;
      if (cfg[CFG_FAST]) begin
        nq = dsrc;
      end else begin
        case (ftype)
          FF_D: nq = tot;
          FF_T: nq = q ^ tot;
          FF_JK: nq = (tot & ~q) | (~kterm & q);
          FF_SR: nq = tot ? 1'b1 : (kterm ? 1'b0 : q);
          default: nq = tot;
        endcase
      end
      pre = hit[i*TERMS_PER_MC + T_PRE];
      clr = hit[i*TERMS_PER_MC + T_CLR] | (cfg[CFG_GCLR_EN] & ~st_q.gclr_s2);
      if (!st_q.run) begin
        st_d.mc_reg[i] = cfg[CFG_PWRUP];
      end else if (clr) begin
        st_d.mc_reg[i] = 1'b0;
      end else if (pre) begin
        st_d.mc_reg[i] = 1'b1;
      end else if (tick) begin
        st_d.mc_reg[i] = nq;
      end
      if (cfg[CFG_BYPASS] && st_q.run) begin
        st_d.mc_out[i] = tot;
      end else begin
        st_d.mc_out[i] = st_d.mc_reg[i];
      end
      st_d.io_oe[i] = st_q.run & cfg[CFG_OE];
    end

    // ---------------------------------------------------------------
    // AXI4-Lite write channel
    // ---------------------------------------------------------------
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_d.aw_have && st_d.w_have && !st_d.bvalid) begin
      nw = st_d.w_data;
      if (st_d.aw_addr == A_CTRL) begin
        old = {31'h00000000, st_q.run};
        old = merge(old, nw, st_d.w_strb);
        st_d.run = old[CTRL_RUN];
      end else if (st_d.aw_addr == A_GCLK) begin
        old = {28'h0000000, st_q.gclk_cfg};
        old = merge(old, nw, st_d.w_strb);
        st_d.gclk_cfg = old[3:0];
      end else if (st_d.aw_addr == A_ROUTE_LO) begin
        old = merge(st_q.route[31:0], nw, st_d.w_strb);
        st_d.route[31:0] = old;
      end else if (st_d.aw_addr == A_ROUTE_HI) begin
        old = {28'h0000000, st_q.route[NUM_IN-1:32]};
        old = merge(old, nw, st_d.w_strb);
        st_d.route[NUM_IN-1:32] = old[3:0];
      end else if (st_d.aw_addr == A_STATUS || st_d.aw_addr == A_PINS) begin
        werr = 1'b0;
      end else if ((st_d.aw_addr - A_MC_BASE) < MC_SPAN && st_d.aw_addr >= A_MC_BASE) begin
        off = st_d.aw_addr - A_MC_BASE;
        mix = off[5:2];
        old = {20'h00000, st_q.mc_cfg[mix]};
        old = merge(old, nw, st_d.w_strb);
        st_d.mc_cfg[mix] = old[CFG_W-1:0];
      end else if ((st_d.aw_addr - A_TERM_BASE) < TERM_SPAN
                   && st_d.aw_addr >= A_TERM_BASE) begin
        off = st_d.aw_addr - A_TERM_BASE;
        tix = off[10:3];
        if (off[2]) begin
          old = merge(st_q.t_comp[tix][31:0], nw, st_d.w_strb);
          st_d.t_comp[tix] = {old[NUM_IN-33:0], old};
        end else begin
          old = merge(st_q.t_true[tix][31:0], nw, st_d.w_strb);
          st_d.t_true[tix] = {old[NUM_IN-33:0], old};
        end
      end else begin
        werr = 1'b1;
      end
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = werr ? RESP_SLVERR : RESP_OKAY;
    end
    st_d.awready = !st_d.aw_have && !st_d.bvalid;
    st_d.wready = !st_d.w_have && !st_d.bvalid;

    // ---------------------------------------------------------------
    // AXI4-Lite read channel
    // ---------------------------------------------------------------
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_q.arready) begin
      if (s_axi_araddr == A_CTRL) begin
        rdat = {31'h00000000, st_q.run};
      end else if (s_axi_araddr == A_GCLK) begin
        rdat = {28'h0000000, st_q.gclk_cfg};
      end else if (s_axi_araddr == A_ROUTE_LO) begin
        rdat = st_q.route[31:0];
      end else if (s_axi_araddr == A_ROUTE_HI) begin
        rdat = {28'h0000000, st_q.route[NUM_IN-1:32]};
      end else if (s_axi_araddr == A_STATUS) begin
        rdat = {16'h0000, st_q.mc_out};
      end else if (s_axi_araddr == A_PINS) begin
        rdat = {9'h000, st_q.gpin_s2, st_q.gclr_s2, st_q.ded_s2, st_q.io_s2};
      end else if ((s_axi_araddr - A_MC_BASE) < MC_SPAN && s_axi_araddr >= A_MC_BASE) begin
        off = s_axi_araddr - A_MC_BASE;
        rdat = {20'h00000, st_q.mc_cfg[off[5:2]]};
      end else if ((s_axi_araddr - A_TERM_BASE) < TERM_SPAN
                   && s_axi_araddr >= A_TERM_BASE) begin
        off = s_axi_araddr - A_TERM_BASE;
        tix = off[10:3];
        if (off[2]) begin
          rdat = st_q.t_comp[tix][31:0];
        end else begin
          rdat = st_q.t_true[tix][31:0];
        end
      end else begin
        rerr = 1'b1;
      end
      st_d.rvalid = 1'b1;
      st_d.rdata = rdat;
      st_d.rresp = rerr ? RESP_SLVERR : RESP_OKAY;
    end
    st_d.arready = !st_d.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign io_pin_out = st_q.mc_out;
  assign io_pin_oe = st_q.io_oe;

endmodule

// File: mla_pkg.sv
// Purpose: Constants and state type for the sixteen-macrocell logic array block
// Assumes: AXI4-Lite register access, 32-bit data, 12-bit byte addresses
// Notes: Register offsets, field positions and codes are collected here
package mla_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_MC = 16;
  localparam int NUM_IN = 36;
  localparam int NUM_DED = 4;
  localparam int TERMS_PER_MC = 6;
  localparam int NUM_TERMS = NUM_MC * TERMS_PER_MC;
  localparam int CFG_W = 12;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] A_GCLK = 12'h004;
  localparam logic [ADDR_W-1:0] A_ROUTE_LO = 12'h008;
  localparam logic [ADDR_W-1:0] A_ROUTE_HI = 12'h00C;
  localparam logic [ADDR_W-1:0] A_STATUS = 12'h010;
  localparam logic [ADDR_W-1:0] A_PINS = 12'h014;
  localparam logic [ADDR_W-1:0] A_MC_BASE = 12'h040;
  localparam logic [ADDR_W-1:0] A_TERM_BASE = 12'h400;
  localparam logic [ADDR_W-1:0] MC_SPAN = 12'(NUM_MC * 4);
  localparam logic [ADDR_W-1:0] TERM_SPAN = 12'(NUM_TERMS * 8);

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int GCLK_SEL0 = 0;
  localparam int GCLK_INV0 = 1;
  localparam int GCLK_SEL1 = 2;
  localparam int GCLK_INV1 = 3;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_BYPASS = 2;
  localparam int CFG_CLK_LSB = 3;
  localparam int CFG_GSEL = 5;
  localparam int CFG_GCLR_EN = 6;
  localparam int CFG_PWRUP = 7;
  localparam int CFG_LEND = 8;
  localparam int CFG_FAST = 9;
  localparam int CFG_FDLY = 10;
  localparam int CFG_OE = 11;
  localparam int PINS_GCLR = 20;
  localparam int PINS_GCLK_LSB = 21;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FF_D = 2'h0;
  localparam logic [1:0] FF_T = 2'h1;
  localparam logic [1:0] FF_JK = 2'h2;
  localparam logic [1:0] FF_SR = 2'h3;
  localparam logic [1:0] CLK_GLOBAL = 2'h0;
  localparam logic [1:0] CLK_GLOBAL_CE = 2'h1;
  localparam logic [1:0] CLK_ARRAY = 2'h2;
  localparam int T_SUM0 = 0;
  localparam int T_SUM1 = 1;
  localparam int T_SUM2 = 2;
  localparam int T_CLK = 3;
  localparam int T_PRE = 4;
  localparam int T_CLR = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // State of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic [3:0] gclk_cfg;
    logic [NUM_IN-1:0] route;
    logic [NUM_MC-1:0][CFG_W-1:0] mc_cfg;
    logic [NUM_TERMS-1:0][NUM_IN-1:0] t_true;
    logic [NUM_TERMS-1:0][NUM_IN-1:0] t_comp;
    logic [1:0] gpin_s1;
    logic [1:0] gpin_s2;
    logic [1:0] gpin_s3;
    logic gclr_s1;
    logic gclr_s2;
    logic [NUM_DED-1:0] ded_s1;
    logic [NUM_DED-1:0] ded_s2;
    logic [NUM_MC-1:0] io_s1;
    logic [NUM_MC-1:0] io_s2;
    logic [NUM_MC-1:0] io_dly;
    logic [NUM_MC-1:0] ac_prev;
    logic [NUM_MC-1:0] mc_reg;
    logic [NUM_MC-1:0] mc_out;
    logic [NUM_MC-1:0] io_oe;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } mla_state_type;

endpackage

// File: mla_board_model.sv
// Purpose: Board side of the I/O pins of the logic array block
// Assumes: Board holds a level on every pin, device drive overrides it
// Notes: Resolved level feeds the pin inputs back
`timescale 1ns/1ns
module mla_board_model (
  input wire logic [mla_pkg::NUM_MC-1:0] pin_drive, // Board levels
  input wire logic [mla_pkg::NUM_MC-1:0] io_pin_out, // Device drive values
  input wire logic [mla_pkg::NUM_MC-1:0] io_pin_oe, // Device drive enables
  output logic [mla_pkg::NUM_MC-1:0] io_pin_in // Resolved pin levels
);
  import mla_pkg::*;
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // enable picks driver
  assign io_pin_in = (io_pin_oe & io_pin_out) | (~io_pin_oe & pin_drive);
endmodule

// File: mla_logic_array_properties.sv
// Purpose: Bus handshake and pin enable checks for the logic array block
// Assumes: One clock domain, latencies as handed over
// Notes: Bound to every instance of the block
`timescale 1ns/1ns
module mla_logic_array_properties (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [mla_pkg::DATA_W-1:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [mla_pkg::NUM_MC-1:0] io_pin_oe // Pin drive enables
);
  import mla_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Handshake steps
  // ----------------------------------------
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_axi_bvalid) // bus latency
    else $error("write response late");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid) // bus latency
    else $error("read response late");
  a_bresp_stand: assert property (s_axi_bvalid && !s_axi_bready |=> // bus hold
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stand: assert property (s_axi_rvalid && !s_axi_rready |=> // bus hold
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped");
  a_b_release: assert property (s_b_done |=> !s_axi_bvalid) // bus release
    else $error("write response stuck");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) // bus order
    else $error("write taken while answering");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) // bus order
    else $error("read taken while answering");
  a_write_reopen: assert property (s_b_done |-> ##[1:3] s_axi_awready) // bus order
    else $error("write slot not reopened");
  a_reset_quiet: assert property ($rose(aresetn) |-> io_pin_oe == '0 && // quiet pins
    !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
endmodule
bind mla_logic_array mla_logic_array_properties mla_logic_array_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .io_pin_oe(io_pin_oe));

// File: mla_logic_array_tb.sv
// Purpose: Self-checking bench for the logic array block
// Assumes: Bus latencies as handed over, pin effects settle in 8 cycles
// Notes: One task per scenario
`timescale 1ns/1ns
module mla_logic_array_tb;
  import mla_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, gclr_n = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [1:0] gpin = 2'h0, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid;
  logic [NUM_MC-1:0] pin_drv = '0, pin_in, pin_out, pin_oe;
  logic [NUM_DED-1:0] ded = '0;
  int miscompares = 0, n_tests = 0, cycles = 0;
  always #50 aclk = ~aclk;
  mla_logic_array mla_logic_array_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .first_global_clock_pin(gpin[0]), .second_global_clock_pin(gpin[1]),
    .global_clear_pin_n(gclr_n), .ded_in_pin(ded), .io_pin_in(pin_in),
    .io_pin_out(pin_out), .io_pin_oe(pin_oe));
  mla_board_model mla_board_model_inst (
    .pin_drive(pin_drv), .io_pin_out(pin_out), .io_pin_oe(pin_oe), .io_pin_in(pin_in));
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    forever begin
      @(posedge aclk);
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'h1;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    chk("write response", 34'(er), 34'(bresp));
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    forever begin
      @(posedge aclk);
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'h1;
      if (arready) arvalid <= 1'h0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    axi_write(a, d, RESP_OKAY);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk("register read", {er, e}, {r, d & m});
  endtask
  task automatic pulse(input int w);
    gpin[w] <= 1'h1;
    repeat (4) @(posedge aclk);
    gpin[w] <= 1'h0;
    repeat (8) @(posedge aclk);
  endtask
  task automatic step(input logic [15:0] pv, input int tk, input logic [15:0] ex,
      input logic [15:0] m);
    pin_drv <= pv;
    repeat (8) @(posedge aclk);
    if (tk != 0) pulse(tk - 1);
    rchk(A_STATUS, 32'(ex), 32'(m), RESP_OKAY);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rchk(A_CTRL, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    rchk(12'h044, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    wr(A_GCLK, 32'hF);
    rchk(A_GCLK, 32'hF, 32'hF, RESP_OKAY); // clock choice
    axi_write(A_STATUS, 32'hFFFF, RESP_OKAY);
    rchk(A_STATUS, 32'h0, 32'hFFFF, RESP_OKAY);
    axi_write(12'h020, 32'hFFFFFFFF, RESP_SLVERR);
    rchk(12'h020, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(A_GCLK, 32'h0);
  endtask
  task automatic t_powerup();
    wr(12'h050, 32'hC0);
    wr(12'h054, 32'h80);
    rchk(A_STATUS, 32'h30, 32'h30, RESP_OKAY); // start level
    wr(A_CTRL, 32'h1);
    rchk(A_STATUS, 32'h30, 32'h30, RESP_OKAY); // start level
    chk("pin enables", 34'h0, 34'(pin_oe)); // pins released
    gclr_n <= 1'h0;
    repeat (8) @(posedge aclk);
    rchk(A_STATUS, 32'h20, 32'h30, RESP_OKAY); // global clear
    gclr_n <= 1'h1;
  endtask
  task automatic t_fast();
    wr(12'h040, 32'h200);
    wr(12'h044, 32'h600);
    step(16'h0003, 0, 16'h0000, 16'h0003); // no edge no capture
    step(16'h0003, 1, 16'h0003, 16'h0003); // fast capture
    wr(A_GCLK, 32'hC);
    wr(12'h040, 32'h220);
    step(16'h0000, 1, 16'h0001, 16'h0003); // clock select
    step(16'h0000, 2, 16'h0000, 16'h0003); // inverted pin
  endtask
  task automatic t_bypass();
    wr(12'h048, 32'h804);
    wr(12'h460, 32'h01000000);
    step(16'h0100, 0, 16'h0004, 16'h0004); // plain logic
    chk("pin 2 drive", 34'h3, 34'({pin_oe[2], pin_out[2]})); // driver on
    wr(A_ROUTE_LO, 32'hFEFFFFFF);
    step(16'h0100, 0, 16'h0000, 16'h0004); // routing gate
    wr(A_ROUTE_LO, 32'hFFFFFFFF);
  endtask
  task automatic t_modes();
    logic [11:0] ca [14] = '{12'h04C, 12'h058, 12'h05C, 12'h060, 12'h064, 12'h490, 12'h520,
      12'h538, 12'h550, 12'h568, 12'h580, 12'h590, 12'h5B0, 12'h5C0};
    logic [31:0] cd [14] = '{32'h1, 32'h8, 32'h10, 32'h2, 32'h3, 32'h02000000, 32'h04000000,
      32'h08000000, 32'h04000000, 32'h10000000, 32'h02000000, 32'h20000000, 32'h02000000,
      32'h20000000};
    for (int i = 0; i < 14; i++) begin
      wr(ca[i], cd[i]);
    end
    step(16'h0600, 1, 16'h0308, 16'h03C8); // flop kinds
    step(16'h2C00, 1, 16'h0048, 16'h03C8); // clock enable
    step(16'h3C00, 0, 16'h00C8, 16'h03C8); // array clock
    step(16'h3200, 1, 16'h03C0, 16'h03C8); // toggle and set
    step(16'h3200, 1, 16'h02C8, 16'h03C8); // toggle again
  endtask
  task automatic t_prio();
    wr(12'h600, 32'h40000000);
    wr(12'h608, 32'h80000000);
    step(16'h4000, 0, 16'h0400, 16'h0400); // preset term
    step(16'hC000, 0, 16'h0000, 16'h0400); // clear wins
    step(16'h4000, 0, 16'h0400, 16'h0400); // preset again
  endtask
  task automatic t_lend();
    wr(A_ROUTE_LO, 32'hFFFFFFFE);
    wr(12'h614, 32'h1);
    wr(12'h06C, 32'h100);
    wr(12'h070, 32'h4);
    step(16'h0000, 0, 16'h1000, 16'h1800); // terms lent onward
    ded <= 4'h1;
    step(16'h0000, 0, 16'h0000, 16'h1800); // dedicated input
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    wr(A_ROUTE_LO, 32'hFFFFFFFF);
    wr(A_ROUTE_HI, 32'hF);
    t_powerup();
    t_fast();
    t_bypass();
    t_modes();
    t_prio();
    t_lend();
    print_verdict();
  end
endmodule
